// ---- lmsu_mem_model.sv ----
// Memory and memory manager model on the far side of the swap unit
module lmsu_mem_model
  import lmsu_pkg::*;
#(
  parameter logic [31:0] PRESET = 32'h11223344
)
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic req_in,
  input wire logic write_in,
  input wire logic byte_in,
  input wire logic [25:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [1:0] wait_in,
  input wire logic ab_rd_in,
  input wire logic ab_wr_in,
  output logic ready_out,
  output logic abort_out,
  output logic [31:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem_r [4];
  logic [31:0] last_r;
  logic [1:0] cnt_r;
  logic rd_now;
  // Each access completes after the chosen wait; a locked pair is never broken off
  assign ready_out = req_in && (cnt_r == wait_in);
  assign abort_out = ready_out && (write_in ? ab_wr_in : ab_rd_in);
  assign rd_now = ready_out && !write_in;
  // Data lines outside a read show the inverse of the last word
  assign rdata_out = rd_now ? mem_r[addr_in[3:2]] : ~last_r;
  // Wait count, storage and byte lane enables
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      cnt_r <= 2'h0;
      last_r <= 32'h0;
      for (int i = 0; i < 4; i++) begin
        mem_r[i] <= PRESET;
      end
    end else begin
      cnt_r <= (ready_out || !req_in) ? 2'h0 : cnt_r + 2'h1;
      if (rd_now) begin
        last_r <= rdata_out;
      end
      if (ready_out && write_in && !abort_out) begin
        if (byte_in) begin
          mem_r[addr_in[3:2]][8*addr_in[1:0] +: 8] <= wdata_in[8*addr_in[1:0] +: 8];
        end else begin
          mem_r[addr_in[3:2]] <= wdata_in;
        end
      end
    end
  end
endmodule : lmsu_mem_model

// ---- lmsu_pkg.sv ----
package lmsu_pkg;

  localparam int LMSU_ADDR_W = 26;
  localparam int LMSU_DATA_W = 32;
  localparam logic [25:0] LMSU_PC_BASE_OFS = 26'h0000008;
  localparam logic [25:0] LMSU_PC_STORE_OFS = 26'h000000c;
  localparam int LMSU_ADDR_TOP_LSB = 26;
  localparam logic [1:0] LMSU_MODE_USER = 2'h0;

  // Status word fields beside the program counter
  typedef struct packed {
    logic [3:0] flags;
    logic irq_dis;
    logic fiq_dis;
    logic [1:0] mode;
  } lmsu_psr_s;

  typedef enum logic [1:0] {
    LMSU_IDLE = 2'b00,
    LMSU_READ = 2'b01,
    LMSU_WRITE = 2'b10
  } lmsu_state_e;

  // Whole state of the swap unit
  typedef struct packed {
    lmsu_state_e st;
    logic [25:0] addr;
    logic byte_op;
    logic dst_pc;
    logic [31:0] wdata;
    logic abort_seen;
    logic mem_req;
    logic mem_write;
    logic lock;
    logic nocache;
    logic cache_upd;
    logic busy;
    logic rd_we;
    logic [31:0] rd_data;
    logic rd_pc_only;
    logic trap_addr;
    logic trap_abort;
  } lmsu_state_s;

  localparam lmsu_state_s LMSU_STATE_RST = '{st: LMSU_IDLE, default: '0};

endpackage : lmsu_pkg

// ---- lmsu_steer.sv ----
// Read data steering: byte pick or word rotation, result held in a register
module lmsu_steer
  import lmsu_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic load_in,
  input wire logic byte_in,
  input wire logic [1:0] lane_in,
  input wire logic [31:0] rdata_in,
  output logic [31:0] data_out
);

  typedef struct packed {
    logic [31:0] data;
  } lmsu_steer_s;

  lmsu_steer_s s_r;
  lmsu_steer_s s_nxt;
  logic [31:0] rot;

  // Rotate right by whole bytes so the addressed byte lands at the bottom
  always_comb begin
    unique case (lane_in)
      2'h0: rot = rdata_in;
      2'h1: rot = {rdata_in[7:0], rdata_in[31:8]};
      2'h2: rot = {rdata_in[15:0], rdata_in[31:16]};
      2'h3: rot = {rdata_in[23:0], rdata_in[31:24]};
    endcase
  end

  // Byte keeps the low lane only, word keeps the whole rotation
  always_comb begin
    s_nxt = s_r;
    if (load_in) begin
      if (byte_in) begin
        s_nxt.data = {24'h000000, rot[7:0]};
      end else begin
        s_nxt.data = rot;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      s_r <= '0;
    end else if (clk_en_in) begin
      s_r <= s_nxt;
    end
  end

  assign data_out = s_r.data;

endmodule : lmsu_steer

// ---- lmsu_swap_unit.sv ----
// Locked read-then-write exchange between a register and external memory
//
// Implementation choices: the strobed register port and the register addresses.
module lmsu_swap_unit
  import lmsu_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic start_in,
  input wire logic cond_pass_in,
  input wire logic byte_sel_in,
  input wire logic base_is_pc_in,
  input wire logic src_is_pc_in,
  input wire logic dst_is_pc_in,
  input wire logic [31:0] base_value_in,
  input wire logic [31:0] src_value_in,
  input wire logic [25:0] instr_addr_in,
  input wire lmsu_psr_s psr_in,
  input wire logic mem_ready_in,
  input wire logic mem_abort_in,
  input wire logic [31:0] mem_rdata_in,
  output logic [25:0] mem_addr_out,
  output logic mem_req_out,
  output logic mem_write_out,
  output logic mem_byte_out,
  output logic mem_lock_out,
  output logic mem_nocache_out,
  output logic mem_cache_upd_out,
  output logic [31:0] mem_wdata_out,
  output logic busy_out,
  output logic irq_hold_out,
  output logic rd_we_out,
  output logic [31:0] rd_data_out,
  output logic rd_pc_only_out,
  output logic trap_addr_exc_out,
  output logic trap_abort_out
);

  lmsu_state_s s_r;
  lmsu_state_s s_nxt;
  logic [31:0] steer_data;
  logic steer_load;
  logic take;
  logic status_top;
  logic [25:0] pc_base;
  logic [25:0] pc_store;
  logic [31:0] eff_base;
  logic addr_bad;
  logic [31:0] src_word;

  // A request is taken only from idle; the clock enable acts at the state register
  assign take = start_in && (s_r.st == LMSU_IDLE);

  // Counter based address and stored counter value
  assign status_top = (|psr_in.flags) || psr_in.irq_dis || psr_in.fiq_dis;
  assign pc_base = instr_addr_in + LMSU_PC_BASE_OFS;
  assign pc_store = instr_addr_in + LMSU_PC_STORE_OFS;

  // Effective base: register contents, or counter with status when it is the base
  always_comb begin
    if (base_is_pc_in) begin
      eff_base = {psr_in.flags, psr_in.irq_dis, psr_in.fiq_dis, pc_base[25:2], psr_in.mode};
    end else begin
      eff_base = base_value_in;
    end
  end

  // Any top address bit set is illegal; for the counter base this is the status bits
  assign addr_bad = base_is_pc_in ? status_top : (|base_value_in[31:LMSU_ADDR_TOP_LSB]);

  // Word written to memory
  always_comb begin
    if (src_is_pc_in) begin
      src_word = {psr_in.flags, psr_in.irq_dis, psr_in.fiq_dis, pc_store[25:2], psr_in.mode};
    end else begin
      src_word = src_value_in;
    end
  end

  // Latch read data into the steering register when the read completes
  assign steer_load = (s_r.st == LMSU_READ) && mem_ready_in;

  lmsu_steer u_steer (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .load_in(steer_load),
    .byte_in(s_r.byte_op),
    .lane_in(s_r.addr[1:0]),
    .rdata_in(mem_rdata_in),
    .data_out(steer_data)
  );

  // Sequencer: idle, locked read, locked write, then commit or trap
  always_comb begin
    s_nxt = s_r;
    s_nxt.rd_we = 1'b0;
    s_nxt.trap_addr = 1'b0;
    s_nxt.trap_abort = 1'b0;
    unique case (s_r.st)
      LMSU_IDLE: begin
        if (take && cond_pass_in) begin
          if (addr_bad) begin
            s_nxt.trap_addr = 1'b1;
          end else begin
            s_nxt.st = LMSU_READ;
            s_nxt.addr = eff_base[25:0];
            s_nxt.byte_op = byte_sel_in;
            s_nxt.dst_pc = dst_is_pc_in;
            if (byte_sel_in) begin
              s_nxt.wdata = {4{src_word[7:0]}};
            end else begin
              s_nxt.wdata = src_word;
            end
            s_nxt.abort_seen = 1'b0;
            s_nxt.mem_req = 1'b1;
            s_nxt.mem_write = 1'b0;
            s_nxt.lock = 1'b1;
            s_nxt.nocache = 1'b1;
            s_nxt.cache_upd = 1'b0;
            s_nxt.busy = 1'b1;
          end
        end
      end
      LMSU_READ: begin
        if (mem_ready_in) begin
          s_nxt.st = LMSU_WRITE;
          s_nxt.abort_seen = mem_abort_in;
          s_nxt.mem_write = 1'b1;
          s_nxt.nocache = 1'b0;
          s_nxt.cache_upd = 1'b1;
        end
      end
      LMSU_WRITE: begin
        if (mem_ready_in) begin
          s_nxt.st = LMSU_IDLE;
          s_nxt.mem_req = 1'b0;
          s_nxt.mem_write = 1'b0;
          s_nxt.lock = 1'b0;
          s_nxt.cache_upd = 1'b0;
          s_nxt.busy = 1'b0;
          if (s_r.abort_seen || mem_abort_in) begin
            s_nxt.trap_abort = 1'b1;
          end else begin
            s_nxt.rd_we = 1'b1;
            s_nxt.rd_data = steer_data;
            s_nxt.rd_pc_only = s_r.dst_pc;
          end
        end
      end
      default: begin
        s_nxt = LMSU_STATE_RST;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      s_r <= LMSU_STATE_RST;
    end else if (clk_en_in) begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign mem_addr_out = s_r.addr;
  assign mem_req_out = s_r.mem_req;
  assign mem_write_out = s_r.mem_write;
  assign mem_byte_out = s_r.byte_op;
  assign mem_lock_out = s_r.lock;
  assign mem_nocache_out = s_r.nocache;
  assign mem_cache_upd_out = s_r.cache_upd;
  assign mem_wdata_out = s_r.wdata;
  assign busy_out = s_r.busy;
  assign irq_hold_out = s_r.lock;
  assign rd_we_out = s_r.rd_we;
  assign rd_data_out = s_r.rd_data;
  assign rd_pc_only_out = s_r.rd_pc_only;
  assign trap_addr_exc_out = s_r.trap_addr;
  assign trap_abort_out = s_r.trap_abort;

  // Checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);

  logic [31:0] wdata_src_q;
  logic take_ok_q;

  // Helper: word to be written, captured when a legal swap is taken
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      wdata_src_q <= '0;
    end else if (clk_en_in && take && cond_pass_in && !addr_bad) begin
      wdata_src_q <= src_word;
    end
  end

  sequence s_read_done;
    clk_en_in && s_r.st == LMSU_READ && mem_ready_in;
  endsequence

  sequence s_write_locked;
    mem_write_out && mem_lock_out && irq_hold_out;
  endsequence

  property p_cond_fail;
    clk_en_in && take && !cond_pass_in |=> !mem_req_out && !trap_addr_exc_out && !busy_out;
  endproperty
  a_cond_fail: assert property (p_cond_fail) else $error("Swap acted with condition false");

  property p_read_then_write;
    s_read_done |=> s_write_locked ##0 (mem_addr_out == $past(mem_addr_out));
  endproperty
  a_read_then_write: assert property (p_read_then_write) else $error("Write did not follow read");

  property p_lock_over_req;
    mem_req_out |-> mem_lock_out;
  endproperty
  a_lock_over_req: assert property (p_lock_over_req) else $error("Memory access without lock");

  property p_read_uncached;
    mem_req_out && !mem_write_out |-> mem_nocache_out && !mem_cache_upd_out;
  endproperty
  a_read_uncached: assert property (p_read_uncached) else $error("Swap read may hit cache");

  property p_byte_repeat;
    mem_write_out && mem_byte_out |-> mem_wdata_out == {4{mem_wdata_out[7:0]}};
  endproperty
  a_byte_repeat: assert property (p_byte_repeat) else $error("Byte not on all lanes");

  property p_word_exact;
    mem_write_out && !mem_byte_out |-> mem_wdata_out == wdata_src_q;
  endproperty
  a_word_exact: assert property (p_word_exact) else $error("Word write altered");

  property p_bad_addr;
    clk_en_in && take && cond_pass_in && addr_bad |=> trap_addr_exc_out && !mem_req_out;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("Illegal address not trapped");

  property p_abort_no_commit;
    clk_en_in && s_r.st == LMSU_WRITE && mem_ready_in && (mem_abort_in || s_r.abort_seen)
      |=> trap_abort_out && !rd_we_out;
  endproperty
  a_abort_no_commit: assert property (p_abort_no_commit) else $error("Aborted swap committed");

  property p_byte_zero_ext;
    rd_we_out && $past(mem_byte_out, 2) |-> rd_data_out[31:8] == 24'h000000;
  endproperty
  a_byte_zero_ext: assert property (p_byte_zero_ext) else $error("Byte result not zero extended");

  logic dst_pc_q;

  // Helper: whether the destination is the counter, captured with a legal request
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      dst_pc_q <= 1'b0;
    end else if (clk_en_in && take && cond_pass_in && !addr_bad) begin
      dst_pc_q <= dst_is_pc_in;
    end
  end

  sequence s_taken;
    clk_en_in && take && cond_pass_in && !addr_bad;
  endsequence

  sequence s_write_done;
    clk_en_in && s_r.st == LMSU_WRITE && mem_ready_in;
  endsequence

  // A fresh access always opens with the locked read
  property p_read_first;
    $rose(mem_req_out) |-> !mem_write_out && mem_lock_out && irq_hold_out;
  endproperty
  a_read_first: assert property (p_read_first) else $error("Access did not open with a locked read");

  // Request and its qualifiers stand until the memory answers
  property p_hold_until_ready;
    clk_en_in && mem_req_out && !mem_ready_in
      |=> mem_req_out && $stable(mem_addr_out) && $stable(mem_write_out) && $stable(mem_wdata_out);
  endproperty
  a_hold_until_ready: assert property (p_hold_until_ready) else $error("Request changed before ready");

  // Low clock enable freezes the whole state
  property p_freeze;
    !clk_en_in |=> $stable(s_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("State moved with clock enable low");

  // Commit only after a clean write completes, and the link goes quiet
  property p_commit_clean;
    s_write_done ##0 (!mem_abort_in && !s_r.abort_seen)
      |=> rd_we_out && !trap_abort_out && !mem_req_out && !mem_lock_out;
  endproperty
  a_commit_clean: assert property (p_commit_clean) else $error("Clean swap not committed");

  // Address taken from the base register contents
  property p_addr_base;
    s_taken ##0 !base_is_pc_in |=> mem_addr_out == $past(base_value_in[25:0]);
  endproperty
  a_addr_base: assert property (p_addr_base) else $error("Swap address not from base register");

  // Counter base: instruction address plus eight, mode bits as byte offset
  property p_pc_base_addr;
    s_taken ##0 base_is_pc_in
      |=> mem_addr_out[25:2] == $past(instr_addr_in[25:2]) + LMSU_PC_BASE_OFS[25:2]
        && mem_addr_out[1:0] == $past(psr_in.mode);
  endproperty
  a_pc_base_addr: assert property (p_pc_base_addr) else $error("Counter based address wrong");

  // Counter source: stored counter is the instruction address plus twelve, status on top
  property p_pc_store;
    s_taken ##0 (src_is_pc_in && !byte_sel_in)
      |=> mem_wdata_out[25:2] == $past(instr_addr_in[25:2]) + LMSU_PC_STORE_OFS[25:2]
        && mem_wdata_out[31:26] == $past(psr_in[7:2]);
  endproperty
  a_pc_store: assert property (p_pc_store) else $error("Stored counter word wrong");

  // Byte select decides the access size
  property p_byte_flag;
    s_taken |=> mem_byte_out == $past(byte_sel_in);
  endproperty
  a_byte_flag: assert property (p_byte_flag) else $error("Access size does not follow byte select");

  // A counter destination is marked so the status word is kept
  property p_dst_pc;
    rd_we_out |-> rd_pc_only_out == dst_pc_q;
  endproperty
  a_dst_pc: assert property (p_dst_pc) else $error("Counter destination not marked");

  // Read fault is remembered into the locked write cycle
  property p_abort_recorded;
    s_read_done ##0 mem_abort_in |=> s_r.abort_seen && mem_write_out && mem_lock_out;
  endproperty
  a_abort_recorded: assert property (p_abort_recorded) else $error("Read fault not recorded");

  // Abort trap is a single pulse with no commit beside it
  property p_trap_pulse;
    clk_en_in && trap_abort_out |=> !trap_abort_out && !rd_we_out;
  endproperty
  a_trap_pulse: assert property (p_trap_pulse) else $error("Abort trap not a single pulse");

  // Address exception makes no access and no commit
  property p_addr_trap_quiet;
    trap_addr_exc_out |-> !mem_req_out && !rd_we_out && !busy_out;
  endproperty
  a_addr_trap_quiet: assert property (p_addr_trap_quiet) else $error("Access made with address exception");

  // Write cycle may update the cache and is not forced past it
  property p_write_cache;
    mem_req_out && mem_write_out |-> mem_cache_upd_out && !mem_nocache_out;
  endproperty
  a_write_cache: assert property (p_write_cache) else $error("Swap write cannot update cache");

endmodule : lmsu_swap_unit

// ---- lmsu_swap_unit_tb_top.sv ----
// Self-checking bench for the swap unit
module lmsu_swap_unit_tb_top import lmsu_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in, rst_b_in, start, cond, bsel, bpc, spc, dpc, abr, abw, rdy, abt, req, wr, mbyte;
  logic [31:0] base, src, rdat, wdat, rd_data, wd;
  logic [25:0] iaddr, maddr, ra;
  logic [7:0] processor_status_word;
  logic [1:0] wt;
  logic [2:0] kind;
  logic pc_only, lock, nocache, cupd, busy, hold, rd_we, t_addr, t_abort, clk_en, pc_o;
  int num_errors, cmp_count, n_acc, na, cyc;
  logic [7:0] pst [5] = '{8'h00, 8'h00, 8'h80, 8'h08, 8'h04};
  lmsu_swap_unit u_lmsu_swap_unit (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en),
    .start_in(start), .cond_pass_in(cond), .byte_sel_in(bsel), .base_is_pc_in(bpc),
    .src_is_pc_in(spc), .dst_is_pc_in(dpc), .base_value_in(base), .src_value_in(src),
    .instr_addr_in(iaddr), .psr_in(processor_status_word), .mem_ready_in(rdy), .mem_abort_in(abt),
    .mem_rdata_in(rdat), .mem_addr_out(maddr), .mem_req_out(req), .mem_write_out(wr),
    .mem_byte_out(mbyte), .mem_lock_out(lock), .mem_nocache_out(nocache),
    .mem_cache_upd_out(cupd), .mem_wdata_out(wdat), .busy_out(busy), .irq_hold_out(hold),
    .rd_we_out(rd_we), .rd_data_out(rd_data), .rd_pc_only_out(pc_o),
    .trap_addr_exc_out(t_addr), .trap_abort_out(t_abort));
  lmsu_mem_model u_lmsu_mem_model (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .req_in(req),
    .write_in(wr), .byte_in(mbyte), .addr_in(maddr), .wdata_in(wdat), .wait_in(wt),
    .ab_rd_in(abr), .ab_wr_in(abw), .ready_out(rdy), .abort_out(abt), .rdata_out(rdat));
  // Clock at 100 ns period
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // Memory side settings: wait cycles and faults on read or write
  task automatic knobs(input logic [1:0] w, input logic ar, input logic aw);
    @(posedge mclk_in);
    wt <= w;
    abr <= ar;
    abw <= aw;
  endtask : knobs
  // Issue one instruction and wait for commit or trap
  task automatic swap(input logic c, b, bp, sp, dp, input logic [31:0] bv, sv, input logic [7:0] ps);
    @(posedge mclk_in);
    start <= 1'b1;
    cond <= c;
    bsel <= b;
    bpc <= bp;
    spc <= sp;
    dpc <= dp;
    base <= bv;
    src <= sv;
    processor_status_word <= ps;
    @(posedge mclk_in);
    start <= 1'b0;
    kind = 3'h0;
    // Look just after the take edge too, so a one-cycle address trap is seen
    for (int i = 0; i < 20 && kind == 3'h0; i++) begin
      #1;
      kind = {t_abort, t_addr, rd_we};
      pc_only = rd_we & pc_o;
      if (kind == 3'h0) @(posedge mclk_in);
    end
  endtask : swap
  // Access monitor on the memory link
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      report_and_stop();
    end
    if (req && rdy) begin
      n_acc++;
      chk(lock & hold & busy, 32'h1);
      chk(nocache, !wr);
      chk(cupd, wr);
      if (wr) wd = wdat;
      else ra = maddr;
    end
  end
  initial begin
    {rst_b_in, start, cond, bsel, bpc, spc, dpc, abr, abw} = '0;
    {base, src, processor_status_word, wt, iaddr} = '0;
    clk_en = 1'b1;
    repeat (8) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    swap(0, 0, 0, 0, 0, 32'h0, 32'h5a5a5a5a, 8'h00);
    chk(kind, 3'h0);
    chk(n_acc, 0);
    $display("test cond_false done");
    // Clock enable held low: a request must not be taken
    clk_en <= 1'b0;
    swap(1, 0, 0, 0, 0, 32'h0, 32'h5a5a5a5a, 8'h00);
    clk_en <= 1'b1;
    chk(kind, 3'h0); // Frozen unit
    chk(n_acc, 0); // Frozen unit
    $display("test freeze done");
    swap(1, 0, 0, 0, 0, 32'h0, 32'haabbccdd, 8'h00);
    chk(kind, 3'h1);
    chk(rd_data, 32'h11223344);
    chk(pc_only, 1'b0);
    chk(ra, 26'h0);
    chk(wd, 32'haabbccdd);
    chk(n_acc, 2);
    knobs(2'h2, 0, 0);
    swap(1, 0, 0, 0, 0, 32'h5, 32'h01020304, 8'h00);
    chk(rd_data, 32'h44112233);
    chk(wd, 32'h01020304);
    swap(1, 1, 0, 0, 0, 32'ha, 32'h000000e7, 8'h00);
    chk(rd_data, 32'h00000022);
    chk(wd, 32'he7e7e7e7);
    swap(1, 0, 0, 0, 0, 32'h8, 32'h0, 8'h00);
    chk(rd_data, 32'h11e73344);
    $display("test word_byte done");
    na = n_acc;
    for (int i = 0; i < 5; i++) begin
      swap(1, 0, i > 1, 0, 0, (i == 0) ? 32'h04000000 : (i == 1) ? 32'h80000000 : 32'h0, 32'h0, pst[i]);
      chk(kind, 3'h2);
    end
    chk(n_acc, na);
    $display("test addr_exc done");
    iaddr <= 26'h4;
    swap(1, 0, 1, 1, 0, 32'h0, 32'h0, 8'h03);
    chk(ra, 26'h00f);
    chk(rd_data, 32'h22334411);
    chk(wd, 32'h00000013);
    swap(1, 0, 0, 0, 1, 32'hc, 32'h0, 8'h00);
    chk(kind, 3'h1);
    chk(pc_only, 1'b1);
    chk(rd_data, 32'h00000013);
    $display("test counter done");
    knobs(2'h1, 1, 0);
    swap(1, 0, 0, 0, 0, 32'h4, 32'hffffffff, 8'h00);
    chk(kind, 3'h4);
    chk(rd_data, 32'h00000013);
    knobs(2'h0, 0, 1);
    swap(1, 0, 0, 0, 0, 32'h4, 32'hffffffff, 8'h00);
    chk(kind, 3'h4);
    chk(rd_data, 32'h00000013);
    $display("test abort done");
    report_and_stop();
  end
endmodule : lmsu_swap_unit_tb_top
